// *** logic/tmf_pkg.sv ***
// constants, register map, reset values and field positions for the timer interrupt flag block
`default_nettype none
package tmf_pkg;
  typedef logic [9:0] tmf_index_t;
  // register indexes, byte address is four times the index
  localparam tmf_index_t IDX_SHARED_VALUE = 10'h01e;
  localparam tmf_index_t IDX_MASK_ONE = 10'h022;
  localparam tmf_index_t IDX_FLAG_ONE = 10'h023;
  localparam tmf_index_t IDX_MASK_TWO = 10'h024;
  localparam tmf_index_t IDX_FLAG_TWO = 10'h025;
  localparam tmf_index_t IDX_CONTROL = 10'h026;
  localparam tmf_index_t IDX_EDGE_CONFIG = 10'h027;
  localparam tmf_index_t IDX_CLEAR = 10'h028;
  typedef enum {REG_NONE, REG_SHARED, REG_MASK1, REG_FLAG1, REG_MASK2,
    REG_FLAG2, REG_CONTROL, REG_EDGE, REG_CLEAR} tmf_reg_e;
  // reset values
  localparam logic [7:0] MASK_ONE_RESET = 8'h00;
  localparam logic [7:0] FLAG_ONE_RESET = 8'h00;
  localparam logic [7:0] MASK_TWO_RESET = 8'h00;
  localparam logic [7:0] FLAG_TWO_RESET = 8'h00;
  localparam logic [15:0] SHARED_VALUE_RESET = 16'hffff;
  localparam logic [7:0] EDGE_CONFIG_RESET = 8'h00;
  // field positions
  localparam int MASK_TWO_FLAGS_LSB = 4;
  localparam int CONTROL_SELECT_BIT = 0;
  localparam logic [7:0] MASK_TWO_RW_BITS = 8'hf0;
  // prescaler write window after reset
  localparam int PRESCALE_WINDOW_NS = 256;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int PRESCALE_WINDOW_CYCLES = PRESCALE_WINDOW_NS / CLOCK_PERIOD_NS;
  // divider terminal counts for codes 00..11
  localparam logic [3:0] DIV_LAST_1 = 4'h0;
  localparam logic [3:0] DIV_LAST_4 = 4'h3;
  localparam logic [3:0] DIV_LAST_8 = 4'h7;
  localparam logic [3:0] DIV_LAST_16 = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** logic/tmf_presc_if.sv ***
// prescale select and count tick between top and divider
`timescale 1ns/10ps
`default_nettype none
interface tmf_presc_if;
  logic [1:0] prescale_select;
  logic tick;
  modport top (output prescale_select, input tick);
  modport presc (input prescale_select, output tick);
endinterface
`default_nettype wire

// *** logic/tmf_prescaler.sv ***
// timer clock divider driven by the prescale select
`timescale 1ns/10ps
`default_nettype none
module tmf_prescaler
  import tmf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  tmf_presc_if.presc pif
);
  logic [3:0] count;
  logic [3:0] last;

  // terminal count per select code
  always_comb begin
    unique case (pif.prescale_select)
      2'h0: last = DIV_LAST_1;
      2'h1: last = DIV_LAST_4;
      2'h2: last = DIV_LAST_8;
      2'h3: last = DIV_LAST_16;
    endcase
  end

  // free-running divide counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 4'h0;
    end else if (ce) begin
      if (count >= last) begin
        count <= 4'h0;
      end else begin
        count <= count + 4'h1;
      end
    end
  end

  assign pif.tick = ce && (count >= last);
endmodule
`default_nettype wire

// *** logic/tmf_top.sv ***
// timer interrupt mask and flag block with axi4-lite register access
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module tmf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic test_mode,
  input wire logic [15:0] timer_count,
  input wire logic [3:0] compare_match,
  input wire logic [3:0] capture_pin,
  input wire logic overflow_event,
  input wire logic realtime_event,
  input wire logic accum_overflow_event,
  input wire logic accum_input_event,
  output logic timer_tick,
  output logic [3:0] capture_event,
  output logic shared_chan_select,
  output logic timer_irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tmf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  tmf_presc_if pif ();
  logic [7:0] timer_mask_one;
  logic [7:0] timer_flag_one;
  logic [7:0] timer_mask_two;
  logic [7:0] timer_flag_two;
  logic [15:0] shared_chan_value;
  logic [7:0] edge_config;
  logic prescale_locked;
  logic [7:0] window_count;
  logic [31:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_go;
  logic wr_byte0;
  tmf_reg_e wr_reg;
  logic [7:0] wr_byte;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] clr_one;
  logic [7:0] clr_two;
  logic [3:0] cap_meta;
  logic [3:0] cap_sync;
  logic [3:0] cap_prev;
  logic tick_q;
  logic compare5_match;
  logic test_meta;
  logic test_sync;

  // map a word index onto a register
  function automatic tmf_reg_e decode(input logic [31:0] addr);
    tmf_index_t idx;
    idx = addr[11:2];
    if (addr[31:12] != 20'h00000) begin
      decode = REG_NONE;
    end else begin
      unique case (idx)
        IDX_SHARED_VALUE: decode = REG_SHARED;
        IDX_MASK_ONE: decode = REG_MASK1;
        IDX_FLAG_ONE: decode = REG_FLAG1;
        IDX_MASK_TWO: decode = REG_MASK2;
        IDX_FLAG_TWO: decode = REG_FLAG2;
        IDX_CONTROL: decode = REG_CONTROL;
        IDX_EDGE_CONFIG: decode = REG_EDGE;
        IDX_CLEAR: decode = REG_CLEAR;
        default: decode = REG_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // prescaler

  tmf_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pif(pif)
  );
  assign pif.prescale_select = timer_mask_two[1:0];
  assign timer_tick = pif.tick;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
  assign wr_go = ce && aw_held && w_held && !s_axi_bvalid;
  assign wr_reg = decode(aw_addr);
  assign wr_byte0 = wr_go && w_strb[0];
  assign wr_byte = w_data[7:0];

  // hold address until the pair is complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  // hold data until the pair is complete
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  assign s_axi_arready = ce && !s_axi_rvalid;

  // read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (decode(s_axi_araddr))
          REG_SHARED: s_axi_rdata <= {16'h0000, shared_chan_value};
          REG_MASK1: s_axi_rdata <= {24'h000000, timer_mask_one};
          REG_FLAG1: s_axi_rdata <= {24'h000000, timer_flag_one};
          REG_MASK2: s_axi_rdata <= {24'h000000, timer_mask_two};
          REG_FLAG2: s_axi_rdata <= {24'h000000, timer_flag_two};
          REG_CONTROL: s_axi_rdata <= {31'h00000000, shared_chan_select};
          REG_EDGE: s_axi_rdata <= {24'h000000, edge_config};
          REG_CLEAR: s_axi_rdata <= 32'h00000000;
          REG_NONE: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // first mask register, plain read-write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mask_one <= MASK_ONE_RESET;
    end else if (ce && wr_byte0 && wr_reg == REG_MASK1) begin
      timer_mask_one <= wr_byte;
    end
  end

  // second mask: enables, dead bits and prescale, prescale write-once within the window after reset outside test mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mask_two <= MASK_TWO_RESET;
      prescale_locked <= 1'b0;
    end else if (ce && wr_byte0 && wr_reg == REG_MASK2) begin
      timer_mask_two[7:4] <= wr_byte[7:4];
      timer_mask_two[3:2] <= 2'h0;
      if (test_sync || (!prescale_locked &&
          window_count < 8'(PRESCALE_WINDOW_CYCLES))) begin
        timer_mask_two[1:0] <= wr_byte[1:0];
        prescale_locked <= 1'b1;
      end
    end
  end

  // cycles since reset for the prescale write window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_count <= 8'h00;
    end else if (ce && window_count < 8'(PRESCALE_WINDOW_CYCLES)) begin
      window_count <= window_count + 8'h01;
    end
  end

  // shared channel select and capture edge configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_chan_select <= 1'b0;
      edge_config <= EDGE_CONFIG_RESET;
    end else if (ce && wr_byte0) begin
      if (wr_reg == REG_CONTROL) begin
        shared_chan_select <= wr_byte[CONTROL_SELECT_BIT];
      end
      if (wr_reg == REG_EDGE) begin
        edge_config <= wr_byte;
      end
    end
  end

  // shared value: capture load, or software write in compare mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_chan_value <= SHARED_VALUE_RESET;
    end else if (ce) begin
      if (shared_chan_select && capture_event[3]) begin
        shared_chan_value <= timer_count;
      end else if (!shared_chan_select && wr_go &&
                   wr_reg == REG_SHARED) begin
        if (w_strb[0]) shared_chan_value[7:0] <= w_data[7:0];
        if (w_strb[1]) shared_chan_value[15:8] <= w_data[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event detection

  // two-stage synchroniser for the mode pin, a level from off-chip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_meta <= 1'b0;
      test_sync <= 1'b0;
    end else if (ce) begin
      test_meta <= test_mode;
      test_sync <= test_meta;
    end
  end

  // two-stage synchroniser for capture pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_meta <= 4'h0;
      cap_sync <= 4'h0;
      cap_prev <= 4'h0;
    end else if (ce) begin
      cap_meta <= capture_pin;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
    end
  end

  // edge select per channel: 01 rising, 10 falling, 11 any
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cap
      assign capture_event[g] = ce && (
        (edge_config[2*g] && cap_sync[g] && !cap_prev[g]) ||
        (edge_config[2*g+1] && !cap_sync[g] && cap_prev[g]));
    end
  endgenerate

  // compare 5 checks the counter one cycle after it steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= timer_tick;
    end
  end
  assign compare5_match = tick_q && (timer_count == shared_chan_value);

  ////////////////////////////////////////////////////////////////////////////
  // flags

  assign set_one = {compare_match[0], compare_match[1], compare_match[2],
                    compare_match[3],
                    shared_chan_select ? capture_event[3] : compare5_match,
                    capture_event[0], capture_event[1], capture_event[2]};
  assign set_two = {overflow_event, realtime_event, accum_overflow_event,
                    accum_input_event, 4'h0};
  assign clr_one = (wr_byte0 && wr_reg == REG_FLAG1) ? wr_byte :
                   (wr_go && wr_reg == REG_CLEAR && w_strb[0]) ? wr_byte :
                   8'h00;
  assign clr_two = (wr_byte0 && wr_reg == REG_FLAG2) ? wr_byte :
                   (wr_go && wr_reg == REG_CLEAR && w_strb[1]) ?
                   w_data[15:8] : 8'h00;

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_flag_one <= FLAG_ONE_RESET;
      timer_flag_two <= FLAG_TWO_RESET;
    end else if (ce) begin
      timer_flag_one <= (timer_flag_one & ~clr_one) | set_one;
      timer_flag_two <= ((timer_flag_two & ~clr_two) | set_two) &
                        MASK_TWO_RW_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request

  // one level request from every enabled flag
  assign timer_irq = |(timer_flag_one & timer_mask_one) ||
    |(timer_flag_two[7:MASK_TWO_FLAGS_LSB] &
      timer_mask_two[7:MASK_TWO_FLAGS_LSB]);
endmodule
`default_nettype wire

// *** tb/tmf_properties.sv ***
// port assertions for the timer interrupt mask and flag block
`timescale 1ns/10ps
`default_nettype none
module tmf_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] compare_match,
  input wire logic overflow_event,
  input wire logic realtime_event,
  input wire logic accum_overflow_event,
  input wire logic accum_input_event,
  input wire logic timer_tick,
  input wire logic [3:0] capture_event,
  input wire logic timer_irq,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic evt;
  logic [4:0] gap;
  ////////////////////////////////////////////////////////////////////////////
  // any flag source at the ports pulsing this cycle, compare 5 not included
  assign evt = (|compare_match) || (|capture_event) || overflow_event ||
    realtime_event || accum_overflow_event || accum_input_event;
  // cycles since the last divider tick, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn || timer_tick) gap <= 5'h00;
    else if (ce) gap <= gap + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  irq_rise_cause_a: assert property ($rose(timer_irq) |-> $past(evt) ||
    $past(timer_tick) || $past(timer_tick, 2) || $rose(s_axi_bvalid))
    else $error("interrupt rose without a cause");
  irq_fall_cause_a: assert property ($fell(timer_irq) |->
    $rose(s_axi_bvalid)) else $error("interrupt fell without a write");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=>
    !timer_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  tick_gap_a: assert property (gap < 5'h10)
    else $error("divider tick gap above sixteen");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  freeze_ready_a: assert property (!ce |->
    !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("ready high while frozen");
endmodule
bind tmf_top tmf_properties tmf_properties_i (.aclk, .aresetn, .ce,
  .compare_match, .overflow_event, .realtime_event, .accum_overflow_event,
  .accum_input_event, .timer_tick, .capture_event, .timer_irq,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** tb/tb.sv ***
// randomised self-checking bench for the timer interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tmf_pkg::*;
  localparam logic [31:0] A_SV = 32'(IDX_SHARED_VALUE) * 4;
  localparam logic [31:0] A_M1 = 32'(IDX_MASK_ONE) * 4;
  localparam logic [31:0] A_F1 = 32'(IDX_FLAG_ONE) * 4;
  localparam logic [31:0] A_M2 = 32'(IDX_MASK_TWO) * 4;
  localparam logic [31:0] A_F2 = 32'(IDX_FLAG_TWO) * 4;
  localparam logic [31:0] A_CT = 32'(IDX_CONTROL) * 4;
  localparam logic [31:0] A_ED = 32'(IDX_EDGE_CONFIG) * 4;
  localparam logic [31:0] A_CL = 32'(IDX_CLEAR) * 4;
  logic aclk = 0, aresetn = 0, ce = 1, test_mode = 0;
  logic [15:0] timer_count = 0;
  logic [3:0] compare_match = 0, capture_pin = 0, capture_event;
  logic ovf = 0, rti = 0, aov = 0, ain = 0;
  logic timer_tick, shared_chan_select, timer_irq;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] f1 = 0, f2 = 0, m1 = 0, m2 = 0, v;
  logic [31:0] d;
  int mismatches = 0, cmp_count = 0, cyc = 0, seed = 32'h979b1c6f;
  int pe[4] = '{1, 4, 8, 16};
  ////////////////////////////////////////////////////////////////////////////
  tmf_top tmf_top_i (.aclk, .aresetn, .ce, .test_mode, .timer_count,
    .compare_match, .capture_pin, .overflow_event(ovf), .realtime_event(rti),
    .accum_overflow_event(aov), .accum_input_event(ain), .timer_tick,
    .capture_event, .shared_chan_select, .timer_irq, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // free-running clock and hang guard
  initial begin
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected interrupt level from tracked flags and masks
  function automatic logic xirq();
    return (|(f1 & m1)) || (|(f2 & m2 & 8'hf0));
  endfunction
  task automatic rst();
    @(posedge aclk);
    aresetn <= 0;
    test_mode <= 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
  endtask
  // bus write: both channels offered together, each released when taken
  task automatic wr(input logic [31:0] a, x,
      input logic [1:0] er = RESP_OKAY);
    logic ga, gb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1;
    wvalid <= 1;
    ga = 0;
    gb = 0;
    do begin
      #3;
      ga = ga | awready;
      gb = gb | wready;
      @(posedge aclk);
      if (ga) awvalid <= 0;
      if (gb) wvalid <= 0;
    end while (!(ga && gb));
    // answer is left waiting one edge so the hold checks see it
    do begin
      #3;
      ga = bvalid;
      @(posedge aclk);
    end while (ga !== 1);
    bready <= 1;
    #3;
    r = bresp;
    @(posedge aclk);
    bready <= 0;
    chk(r, er);
  endtask
  // bus read with comparison of data and response
  task automatic rchk(input logic [31:0] a, e,
      input logic [1:0] er = RESP_OKAY);
    logic g;
    logic [31:0] x;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do begin
      #3;
      g = arready;
      @(posedge aclk);
    end while (g !== 1);
    arvalid <= 0;
    do begin
      #3;
      g = rvalid;
      @(posedge aclk);
    end while (g !== 1);
    rready <= 1;
    #3;
    x = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 0;
    chk(x, e);
    chk(r, er);
  endtask
  // one-cycle pulse on compare and flag-two sources
  task automatic kick(input logic [7:0] k);
    @(posedge aclk);
    compare_match <= k[3:0];
    {ovf, rti, aov, ain} <= k[7:4];
    @(posedge aclk);
    compare_match <= 0;
    {ovf, rti, aov, ain} <= 0;
    f1 |= {k[0], k[1], k[2], k[3], 4'h0};
    f2 |= {k[7:4], 4'h0};
  endtask
  // cycles between two divider ticks
  task automatic per(input int e);
    int n;
    n = 0;
    do begin @(posedge aclk); #3; end while (timer_tick !== 1);
    do begin @(posedge aclk); #3; n++; end while (timer_tick !== 1);
    chk(n, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst();
    rchk(A_M1, 0);
    rchk(A_F1, 0);
    rchk(A_M2, 0);
    rchk(A_F2, 0);
    rchk(A_SV, 32'hffff);
    rchk(32'h200, 0, RESP_SLVERR);
    wr(32'h204, 1, RESP_SLVERR);
    test_mode <= 1;
    for (int k = 0; k < 4; k++) begin
      wr(A_M2, k);
      per(pe[k]);
    end
    rst();
    wr(A_M2, 32'hfd);
    rchk(A_M2, 32'hf1);
    wr(A_M2, 32'h02);
    rchk(A_M2, 32'h01);
    per(4);
    wr(A_ED, 32'h55);
    wr(A_SV, 32'h1234);
    @(posedge aclk);
    capture_pin <= 4'h7;
    timer_count <= 16'h1234;
    repeat (12) @(posedge aclk);
    timer_count <= 16'h5555;
    f1 = 8'h0f;
    rchk(A_F1, f1);
    wr(A_CT, 1);
    #3;
    chk(shared_chan_select, 1);
    wr(A_SV, 32'habcd);
    rchk(A_SV, 32'h1234);
    wr(A_F1, 32'h08);
    rchk(A_F1, 32'h07);
    @(posedge aclk);
    capture_pin <= 4'hf;
    repeat (2) @(posedge aclk);
    #3;
    chk(capture_event, 4'h8);
    repeat (6) @(posedge aclk);
    rchk(A_F1, f1);
    rchk(A_SV, 32'h5555);
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      m1 = $random(seed);
      m2 = $random(seed);
      kick(v);
      wr(A_M1, m1);
      wr(A_M2, m2);
      rchk(A_M1, m1);
      rchk(A_F1, f1);
      rchk(A_F2, f2);
      #3;
      chk(timer_irq, xirq());
      d = $random(seed);
      if (i[0]) wr(A_CL, d & 32'hffff);
      else begin
        wr(A_F1, d[7:0]);
        wr(A_F2, d[15:8]);
      end
      f1 &= ~d[7:0];
      f2 &= ~d[15:8];
      #3;
      chk(timer_irq, xirq());
    end
    @(posedge aclk);
    ce <= 0;
    @(posedge aclk);
    #3;
    chk(arready, 0);
    @(posedge aclk);
    ce <= 1;
    finish_test();
  end
endmodule
`default_nettype wire
